// ---- rtl/spc_regs.sv ----
// APB register bank for the signal path: bypass switches, readings, die address, filter codes.
// Assumes an APB master on core_clk and readings produced by logic on the same clock.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps

module spc_regs (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [spc_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [spc_pkg::DATA_W-1:0]    pwdata,
  output logic      [spc_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Datapath readings
  input  wire logic [spc_pkg::READING_W-1:0] temp_value,
  input  wire logic [spc_pkg::READING_W-1:0] field_value,
  // Datapath controls
  output spc_pkg::spc_bypass_t               bypass,
  output logic      [1:0]                    die_address,
  output logic      [2:0]                    calibration_filter_code,
  output logic      [2:0]                    signal_filter_code,
  output logic      [2:0]                    coil_self_test_filter
);

  localparam int IDX_W = spc_pkg::ADDR_W - 2;

  if (IDX_W < 8)
  begin : g_addr_check
    $error("spc_regs: address too narrow for the register map");
  end

  if (spc_pkg::NV_DATA_W + spc_pkg::NV_CHECK_W != spc_pkg::DATA_W)
  begin : g_word_check
    $error("spc_regs: nonvolatile data and check bits must fill one word");
  end

  if (spc_pkg::BYPASS_W != $bits(spc_pkg::spc_bypass_t))
  begin : g_bypass_check
    $error("spc_regs: bypass field width does not match its switch set");
  end

  if (spc_pkg::DIE_ADDR_HI >= spc_pkg::NV_DATA_W || spc_pkg::CAL_CODE_HI >= spc_pkg::NV_DATA_W)
  begin : g_field_check
    $error("spc_regs: a parameter field overlaps the check bits");
  end

  logic [7:0]                 idx;
  logic                       access;
  logic                       start;
  logic                       done;
  logic                       wr;
  logic [spc_pkg::DATA_W-1:0] die_word;
  logic [spc_pkg::DATA_W-1:0] bw_word;
  logic [spc_pkg::DATA_W-1:0] next_rdata;

  function automatic logic is_reserved(input logic [7:0] i);
    return (i >= spc_pkg::IDX_RSV_FIRST) && (i <= spc_pkg::IDX_RSV_LAST);
  endfunction : is_reserved

  function automatic logic is_mapped(input logic [7:0] i);
    logic m;
    m = 1'b0;
    if (i == spc_pkg::IDX_DIE_WORD)
      m = 1'b1;
    else if (i == spc_pkg::IDX_BW_WORD)
      m = 1'b1;
    else if (i == spc_pkg::IDX_BYPASS)
      m = 1'b1;
    else if (i == spc_pkg::IDX_TEMP)
      m = 1'b1;
    else if (i == spc_pkg::IDX_FIELD)
      m = 1'b1;
    else if (is_reserved(i))
      m = 1'b1;
    return m;
  endfunction : is_mapped

  // Byte offsets within a word are ignored; every register is one aligned word
  assign idx    = paddr[spc_pkg::ADDR_W-1:2];
  assign access = psel && penable;
  assign start  = access && !pready;
  assign done   = access && pready;
  assign wr     = done && pwrite && is_mapped(idx);

  // One wait state: pready rises in the cycle after the access phase begins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= start;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pslverr <= 1'b0;
    else
      pslverr <= start && !is_mapped(idx);
  end

  always_comb
  begin
    next_rdata = '0;
    if (idx == spc_pkg::IDX_DIE_WORD)
      next_rdata = die_word;
    else if (idx == spc_pkg::IDX_BW_WORD)
      next_rdata = bw_word;
    else if (idx == spc_pkg::IDX_BYPASS)
      next_rdata = {27'h0000000, bypass};
    else if (idx == spc_pkg::IDX_TEMP)
      next_rdata = {20'h00000, temp_value};
    else if (idx == spc_pkg::IDX_FIELD)
      next_rdata = {20'h00000, field_value};
    else if (is_reserved(idx))
      next_rdata = '0;
  end

  // Read data is latched with pready so it is stable for the whole answer cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prdata <= '0;
    else if (start && !pwrite)
      prdata <= next_rdata;
  end

  // Bypass switches; readings and reserved indices have no storage, so writes there vanish
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      bypass <= spc_pkg::BYPASS_RESET;
    else if (wr && idx == spc_pkg::IDX_BYPASS)
      bypass <= spc_pkg::spc_bypass_t'(pwdata[spc_pkg::BYPASS_W-1:0]);
  end

  spc_nv_word #(
    .RESET_DATA (spc_pkg::DIE_WORD_RESET)
  ) u_die_word (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr && idx == spc_pkg::IDX_DIE_WORD),
    .wr_data  (pwdata[spc_pkg::NV_DATA_W-1:0]),
    .word     (die_word)
  );

  spc_nv_word #(
    .RESET_DATA (spc_pkg::BW_WORD_RESET)
  ) u_bw_word (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr && idx == spc_pkg::IDX_BW_WORD),
    .wr_data  (pwdata[spc_pkg::NV_DATA_W-1:0]),
    .word     (bw_word)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      die_address <= spc_pkg::DIE_ADDRESS_RESET;
    else
      die_address <= die_word[spc_pkg::DIE_ADDR_HI:spc_pkg::DIE_ADDR_LO];
  end

  spc_bw_decode u_cal_decode (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .code     (bw_word[spc_pkg::CAL_CODE_HI:spc_pkg::CAL_CODE_LO]),
    .corner   (calibration_filter_code)
  );

  spc_bw_decode u_sig_decode (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .code     (bw_word[spc_pkg::SIG_CODE_HI:spc_pkg::SIG_CODE_LO]),
    .corner   (signal_filter_code)
  );

  // The self test path has its own fixed corner so its timing does not follow the code
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      coil_self_test_filter <= spc_pkg::COIL_TEST_CODE;
    else
      coil_self_test_filter <= spc_pkg::COIL_TEST_CODE;
  end

  // Checks next to the logic

  property p_skip_tc;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BYPASS) |=> (bypass.skip_temp_compensation == $past(pwdata[1]));
  endproperty
  a_skip_tc: assert property (p_skip_tc) else $error("temperature compensation bypass not taken");

  property p_skip_lin;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BYPASS) |=> (bypass.skip_linearization == $past(pwdata[2]));
  endproperty
  a_skip_lin: assert property (p_skip_lin) else $error("linearization bypass not taken");

  property p_skip_plin;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BYPASS) |=> (bypass.skip_post_lin_trim == $past(pwdata[3]));
  endproperty
  a_skip_plin: assert property (p_skip_plin) else $error("post trim bypass not taken");

  property p_skip_clamp;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BYPASS)
      |=> (bypass.skip_clamp == $past(pwdata[4]) && bypass.skip_trim == $past(pwdata[0]));
  endproperty
  a_skip_clamp: assert property (p_skip_clamp) else $error("clamp or trim bypass not taken");

  property p_temp_read;
    @(posedge core_clk) disable iff (!rst_n)
    (start && !pwrite && idx == spc_pkg::IDX_TEMP) |=> (pready && prdata == {20'h00000, $past(temp_value)});
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temperature reading wrong");

  property p_field_read;
    @(posedge core_clk) disable iff (!rst_n)
    (start && !pwrite && idx == spc_pkg::IDX_FIELD)
      |=> (pready && !pslverr && prdata == {20'h00000, $past(field_value)});
  endproperty
  a_field_read: assert property (p_field_read) else $error("field reading wrong");

  property p_reserved;
    @(posedge core_clk) disable iff (!rst_n)
    (start && is_reserved(idx)) |=> (pready && !pslverr && (pwrite || prdata == 32'h00000000))
      ##1 ($stable(bypass) && $stable(die_word) && $stable(bw_word));
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved index answered wrongly");

  property p_nv_check;
    @(posedge core_clk) disable iff (!rst_n)
    (start && !pwrite && (idx == spc_pkg::IDX_DIE_WORD || idx == spc_pkg::IDX_BW_WORD))
      |=> (prdata[31:26] == spc_pkg::nv_check(prdata[25:0]));
  endproperty
  a_nv_check: assert property (p_nv_check) else $error("nonvolatile check bits inconsistent");

  property p_die_addr;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_DIE_WORD) |=> ##1 (die_address == $past(pwdata[23:22], 2));
  endproperty
  a_die_addr: assert property (p_die_addr) else $error("die address not taken from word");

  property p_cal_code;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BW_WORD) |=> ##1
      (calibration_filter_code == (($past(pwdata[21:19], 2) > 3'h4) ? 3'h4 : $past(pwdata[21:19], 2)));
  endproperty
  a_cal_code: assert property (p_cal_code) else $error("calibration corner wrong");

  property p_coil_fixed;
    @(posedge core_clk) disable iff (!rst_n)
    ##1 $stable(coil_self_test_filter) && coil_self_test_filter == spc_pkg::COIL_TEST_CODE;
  endproperty
  a_coil_fixed: assert property (p_coil_fixed) else $error("self test corner moved");

  property p_sig_code;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BW_WORD) |=> ##1
      (signal_filter_code == (($past(pwdata[18:16], 2) > 3'h4) ? 3'h4 : $past(pwdata[18:16], 2)));
  endproperty
  a_sig_code: assert property (p_sig_code) else $error("signal corner wrong");

  property p_ro_write;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && (idx == spc_pkg::IDX_TEMP || idx == spc_pkg::IDX_FIELD))
      |=> ($stable(bypass) && $stable(die_word) && $stable(bw_word));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to a reading changed state");

  property p_one_wait;
    @(posedge core_clk) disable iff (!rst_n)
    start |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not given after one wait state");

  property p_ready_pulse;
    @(posedge core_clk) disable iff (!rst_n)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("answer held for more than one cycle");

  property p_unmapped;
    @(posedge core_clk) disable iff (!rst_n)
    (start && !is_mapped(idx)) |=> (pready && pslverr && (pwrite || prdata == 32'h00000000))
      ##1 ($stable(bypass) && $stable(die_word) && $stable(bw_word));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index answered wrongly");

  property p_die_data;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_DIE_WORD) |=> (die_word[25:0] == $past(pwdata[25:0]));
  endproperty
  a_die_data: assert property (p_die_data) else $error("die word data not stored");

  property p_bw_data;
    @(posedge core_clk) disable iff (!rst_n)
    (wr && idx == spc_pkg::IDX_BW_WORD) |=> (bw_word[25:0] == $past(pwdata[25:0]));
  endproperty
  a_bw_data: assert property (p_bw_data) else $error("bandwidth word data not stored");

  property p_bypass_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !(wr && idx == spc_pkg::IDX_BYPASS) |=> $stable(bypass);
  endproperty
  a_bypass_hold: assert property (p_bypass_hold) else $error("bypass switches moved without a write");

  property p_bypass_read;
    @(posedge core_clk) disable iff (!rst_n)
    (start && !pwrite && idx == spc_pkg::IDX_BYPASS) |=> (pready && prdata == {27'h0000000, $past(bypass)});
  endproperty
  a_bypass_read: assert property (p_bypass_read) else $error("bypass switches read back wrongly");

  property p_die_read;
    @(posedge core_clk) disable iff (!rst_n)
    (start && !pwrite && idx == spc_pkg::IDX_DIE_WORD) |=> (pready && prdata == $past(die_word));
  endproperty
  a_die_read: assert property (p_die_read) else $error("die word read back wrongly");

  property p_codes_bound;
    @(posedge core_clk) disable iff (!rst_n)
    (calibration_filter_code <= spc_pkg::CODE_WIDEST) && (signal_filter_code <= spc_pkg::CODE_WIDEST);
  endproperty
  a_codes_bound: assert property (p_codes_bound) else $error("filter corner outside the five settings");

endmodule : spc_regs

// ---- rtl/spc_pkg.sv ----
// Constants, field layouts and carrier types for the signal path configuration registers.
// Assumes a 32-bit APB master and a datapath that consumes the bypass and filter selections.
package spc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DIE_WORD  = 8'h02;
  localparam logic [7:0] IDX_BW_WORD   = 8'h03;
  localparam logic [7:0] IDX_BYPASS    = 8'h47;
  localparam logic [7:0] IDX_TEMP      = 8'h48;
  localparam logic [7:0] IDX_FIELD     = 8'h49;
  localparam logic [7:0] IDX_RSV_FIRST = 8'h4a;
  localparam logic [7:0] IDX_RSV_LAST  = 8'h59;

  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 32;
  localparam int READING_W  = 12;
  localparam int BYPASS_W   = 5;

  // Nonvolatile word layout
  localparam int NV_DATA_W    = 26;
  localparam int NV_CHECK_W   = 6;
  localparam int DIE_ADDR_HI  = 23;
  localparam int DIE_ADDR_LO  = 22;
  localparam int CAL_CODE_HI  = 21;
  localparam int CAL_CODE_LO  = 19;
  localparam int SIG_CODE_HI  = 18;
  localparam int SIG_CODE_LO  = 16;

  localparam logic [NV_DATA_W-1:0] DIE_WORD_RESET = 26'h0000000;
  localparam logic [NV_DATA_W-1:0] BW_WORD_RESET  = 26'h0000000;

  // Reset values of the registered controls derived from the words
  localparam logic [1:0] DIE_ADDRESS_RESET = 2'h0;
  localparam logic [2:0] CORNER_RESET      = 3'h0;

  // Codes 4 to 7 all select the widest corner
  localparam logic [2:0] CODE_WIDEST    = 3'h4;
  // Fixed corner for the coil self test path
  localparam logic [2:0] COIL_TEST_CODE = 3'h4;

  typedef struct packed {
    logic skip_clamp;
    logic skip_post_lin_trim;
    logic skip_linearization;
    logic skip_temp_compensation;
    logic skip_trim;
  } spc_bypass_t;

  localparam spc_bypass_t BYPASS_RESET = 5'h00;

  // Check bits: bit k is the parity of every data bit whose index mod 6 is k
  function automatic logic [NV_CHECK_W-1:0] nv_check(input logic [NV_DATA_W-1:0] d);
    logic [NV_CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < NV_DATA_W; i++)
    begin
      c[i % NV_CHECK_W] = c[i % NV_CHECK_W] ^ d[i];
    end
    return c;
  endfunction : nv_check

endpackage : spc_pkg

// ---- rtl/spc_nv_word.sv ----
// One nonvolatile parameter word with its diagnostic check bits on top.
// Assumes the parent decodes writes; the check bits are always generated here.
`timescale 1ns/10ps
module spc_nv_word #(
  parameter logic [spc_pkg::NV_DATA_W-1:0] RESET_DATA = '0
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // Write side
  input  wire logic                          wr_en,
  input  wire logic [spc_pkg::NV_DATA_W-1:0] wr_data,
  // Stored word
  output logic      [spc_pkg::DATA_W-1:0]    word
);

  logic [spc_pkg::NV_DATA_W-1:0] data;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      data <= RESET_DATA;
    else if (wr_en)
      data <= wr_data;
  end

  // Software cannot forge the check bits, so a read always shows a consistent word
  assign word = {spc_pkg::nv_check(data), data};

endmodule : spc_nv_word

// ---- rtl/spc_bw_decode.sv ----
// Filter corner selector: folds the 3-bit bandwidth code onto five corners.
// Assumes the code comes from logic on the same clock.
`timescale 1ns/10ps
module spc_bw_decode (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Code in, corner out
  input  wire logic [2:0] code,
  output logic      [2:0] corner
);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      corner <= spc_pkg::CORNER_RESET;
    else if (code > spc_pkg::CODE_WIDEST)
      corner <= spc_pkg::CODE_WIDEST;
    else
      corner <= code;
  end

endmodule : spc_bw_decode

// ---- bench/signal_path_config_regs_tb_top.sv ----
// Self-checking bench for the signal path configuration register bank.
// Assumes spc_pkg and the rtl modules are compiled first; the bench drives APB and readings itself.
`timescale 1ns/10ps
module signal_path_config_regs_tb_top;
  logic                 core_clk    = 1'b0;
  logic                 rst_n       = 1'b0;
  logic                 psel        = 1'b0;
  logic                 penable     = 1'b0;
  logic                 pwrite      = 1'b0;
  logic [9:0]           paddr       = 10'h000;
  logic [31:0]          pwdata      = 32'h00000000;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [11:0]          temp_value  = 12'h000;
  logic [11:0]          field_value = 12'h000;
  spc_pkg::spc_bypass_t bypass;
  logic [1:0]           die_address;
  logic [2:0]           cal_code;
  logic [2:0]           sig_code;
  logic [2:0]           coil_code;
  int                   n_errors    = 0;
  int                   checks_done = 0;
  logic [31:0]          lfsr_state  = 32'h00008808;
  logic [31:0]          rd;
  logic                 err;
  logic [31:0]          r;
  logic [25:0]          d;
  logic [4:0]           byp_model;
  logic [7:0]           idx;
  logic [31:0]          exp_q[$];

  always #50 core_clk = ~core_clk;

  spc_regs dut_u (
    .core_clk                (core_clk),
    .rst_n                   (rst_n),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .temp_value              (temp_value),
    .field_value             (field_value),
    .bypass                  (bypass),
    .die_address             (die_address),
    .calibration_filter_code (cal_code),
    .signal_filter_code      (sig_code),
    .coil_self_test_filter   (coil_code)
  );

  function automatic logic [31:0] next_rand();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction : next_rand

  // Stored word model: six parity bits over data bit groups taken by index mod 6
  function automatic logic [31:0] nv_model(input logic [25:0] dat);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 26; i++)
    begin
      c[i % 6] = c[i % 6] ^ dat[i];
    end
    return {c, dat};
  endfunction : nv_model

  function automatic logic [31:0] fold(input int c);
    return (c > 4) ? 32'h4 : 32'(c);
  endfunction : fold

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic e);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    e    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial
  begin
    #5_000_000;
    n_errors++;
    print_verdict();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check({27'h0, bypass}, 32'h0);
    check({30'h0, die_address}, 32'h0);
    check({29'h0, coil_code}, 32'h4);
    // Single bits first, then random patterns with junk in the unused upper bits
    for (int i = 0; i < 10; i++)
    begin
      r = next_rand();
      byp_model = (i < 5) ? (5'h01 << i) : r[4:0];
      apb(1'b1, spc_pkg::IDX_BYPASS, {r[31:5], byp_model}, rd, err);
      #1;
      check({27'h0, bypass}, {27'h0, byp_model});
      check({31'h0, err}, 32'h0);
      apb(1'b0, spc_pkg::IDX_BYPASS, 32'h0, rd, err);
      check(rd, {27'h0, byp_model});
    end
    // Every filter code on both paths, every die address
    for (int i = 0; i < 8; i++)
    begin
      r = next_rand();
      d = r[25:0];
      d[23:22] = i[1:0];
      d[21:19] = i[2:0];
      d[18:16] = 3'(7 - i);
      apb(1'b1, spc_pkg::IDX_DIE_WORD, {~r[31:26], d}, rd, err);
      apb(1'b1, spc_pkg::IDX_BW_WORD, {r[31:26], d}, rd, err);
      @(posedge core_clk);
      #1;
      check({30'h0, die_address}, {30'h0, d[23:22]});
      check({29'h0, cal_code}, fold(i));
      check({29'h0, sig_code}, fold(7 - i));
      check({29'h0, coil_code}, 32'h4);
      apb(1'b0, spc_pkg::IDX_DIE_WORD, 32'h0, rd, err);
      check(rd, nv_model(d));
      apb(1'b0, spc_pkg::IDX_BW_WORD, 32'h0, rd, err);
      check(rd, nv_model(d));
    end
    // Readings are read-only; writes to them change nothing
    for (int i = 0; i < 4; i++)
    begin
      r = next_rand();
      @(posedge core_clk);
      temp_value  <= r[11:0];
      field_value <= r[27:16];
      apb(1'b1, spc_pkg::IDX_TEMP, ~r, rd, err);
      check({31'h0, err}, 32'h0);
      apb(1'b1, spc_pkg::IDX_FIELD, ~r, rd, err);
      check({31'h0, err}, 32'h0);
      exp_q.push_back({20'h0, r[11:0]});
      exp_q.push_back({20'h0, r[27:16]});
      apb(1'b0, spc_pkg::IDX_TEMP, 32'h0, rd, err);
      check(rd, exp_q.pop_front());
      apb(1'b0, spc_pkg::IDX_FIELD, 32'h0, rd, err);
      check(rd, exp_q.pop_front());
    end
    // Factory range edges answer quietly with zero; unmapped places error
    for (int i = 0; i < 4; i++)
    begin
      idx = (i == 0) ? spc_pkg::IDX_RSV_FIRST : (i == 1) ? spc_pkg::IDX_RSV_LAST : (i == 2) ? 8'h10 : 8'hff;
      apb(1'b1, idx, 32'hffffffff, rd, err);
      check({31'h0, err}, {31'h0, i > 1});
      apb(1'b0, idx, 32'h0, rd, err);
      check(rd, 32'h0);
      check({31'h0, err}, {31'h0, i > 1});
      check({27'h0, bypass}, {27'h0, byp_model});
    end
    // Reset in mid-run clears the switches again
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check({27'h0, bypass}, 32'h0);
    check({30'h0, die_address}, 32'h0);
    check({29'h0, cal_code}, 32'h0);
    check({29'h0, sig_code}, 32'h0);
    apb(1'b0, spc_pkg::IDX_BYPASS, 32'h0, rd, err);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule : signal_path_config_regs_tb_top
